// [rtl/dcsfr_consts.svh]
`ifndef DCSFR_CONSTS_SVH
`define DCSFR_CONSTS_SVH

// Printed offsets are not all multiples of four: each is an index, byte address is index times four
`define DCSFR_IDX_SERIAL_CHANNEL_MODE 8'h84
`define DCSFR_IDX_TRANSMIT_QUEUE 8'h85
`define DCSFR_IDX_DMA_CONTROL_0 8'h92
`define DCSFR_IDX_DMA_CONTROL_1 8'h93
`define DCSFR_IDX_BIT_RATE_DIVIDER 8'h94
`define DCSFR_IDX_ADDRESS_MATCH_0 8'h95
`define DCSFR_IDX_CH0_SOURCE_LOW 8'hA2
`define DCSFR_IDX_CH0_SOURCE_HIGH 8'hA3
`define DCSFR_IDX_INTERFRAME_GAP 8'hA4
`define DCSFR_IDX_ADDRESS_MATCH_1 8'hA5
`define DCSFR_IDX_CH1_SOURCE_LOW 8'hB2
`define DCSFR_IDX_CH1_SOURCE_HIGH 8'hB3
`define DCSFR_IDX_SLOT_TIME 8'hB4
`define DCSFR_IDX_ADDRESS_MATCH_2 8'hB5
`define DCSFR_IDX_CH0_DEST_LOW 8'hC2
`define DCSFR_IDX_CH0_DEST_HIGH 8'hC3
`define DCSFR_IDX_BACKOFF_TIMER 8'hC4
`define DCSFR_IDX_ADDRESS_MATCH_3 8'hC5
`define DCSFR_IDX_EXTENSION_IRQ_ENABLE 8'hC8
`define DCSFR_IDX_CH1_DEST_LOW 8'hD2
`define DCSFR_IDX_CH1_DEST_HIGH 8'hD3
`define DCSFR_IDX_COLLISION_COUNT 8'hD4
`define DCSFR_IDX_ADDRESS_MASK_0 8'hD5
`define DCSFR_IDX_TRANSMIT_STATE 8'hD8
`define DCSFR_IDX_CH0_COUNT_LOW 8'hE2
`define DCSFR_IDX_CH0_COUNT_HIGH 8'hE3
`define DCSFR_IDX_PSEUDO_RANDOM_SEQ 8'hE4
`define DCSFR_IDX_ADDRESS_MASK_1 8'hE5
`define DCSFR_IDX_RECEIVE_STATE 8'hE8
`define DCSFR_IDX_CH1_COUNT_LOW 8'hF2
`define DCSFR_IDX_CH1_COUNT_HIGH 8'hF3
`define DCSFR_IDX_RECEIVE_QUEUE 8'hF4
`define DCSFR_IDX_OWN_SLOT_NUMBER 8'hF5
`define DCSFR_IDX_EXTENSION_IRQ_PRIORITY 8'hF8

`define DCSFR_RESET_ZERO 8'h00
`define DCSFR_SERIAL_MODE_RESET 8'h00
`define DCSFR_PADDR_WIDTH 10

`endif

// [rtl/dcsfr_map.sv]
`timescale 1ns/10ps
`include "dcsfr_consts.svh"

module dcsfr_map (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire dcsfr_pkg::dcsfr_apb_req_type apb_req,
  // APB answer
  output dcsfr_pkg::dcsfr_apb_rsp_type apb_rsp,
  // Channel values to the DMA engine
  output dcsfr_pkg::dcsfr_channel_type ch0,
  output dcsfr_pkg::dcsfr_channel_type ch1,
  // Serial channel, DMA and interrupt controls
  output dcsfr_pkg::dcsfr_byte_type serial_channel_mode,
  output dcsfr_pkg::dcsfr_byte_type dma_control_0,
  output dcsfr_pkg::dcsfr_byte_type dma_control_1,
  output dcsfr_pkg::dcsfr_byte_type extension_irq_enable,
  output dcsfr_pkg::dcsfr_byte_type extension_irq_priority,
  // Transmit queue write strobe and byte
  output logic tx_queue_push,
  output dcsfr_pkg::dcsfr_byte_type tx_queue_data,
  // Receive queue pop and engine status
  output logic rx_queue_pop,
  input wire dcsfr_pkg::dcsfr_byte_type rx_queue_data,
  input wire dcsfr_pkg::dcsfr_byte_type transmit_state_in,
  input wire dcsfr_pkg::dcsfr_byte_type receive_state_in,
  input wire dcsfr_pkg::dcsfr_byte_type collision_count_in,
  input wire dcsfr_pkg::dcsfr_byte_type backoff_timer_in
);
  import dcsfr_pkg::*;

  // Plain byte store, one slot per extension index
  dcsfr_byte_type store [256];
  logic [7:0] index;
  logic setup;
  logic access;
  logic wr_fire;
  logic rd_fire;
  logic mapped;
  logic writable;
  dcsfr_byte_type next_rdata;
  logic [31:0] prdata_q;
  logic tx_push_q;
  logic rx_pop_q;
  dcsfr_byte_type tx_data_q;
  // Bytes that leave reset at zero are kept apart from the unreset store
  localparam int ZERO_SLOTS = 10;
  dcsfr_byte_type zeroed [ZERO_SLOTS];
  logic [3:0] zslot;
  logic zeroed_hit;

  function automatic logic is_ext(input logic [7:0] idx);
    unique case (idx)
      `DCSFR_IDX_SERIAL_CHANNEL_MODE, `DCSFR_IDX_TRANSMIT_QUEUE,
      `DCSFR_IDX_DMA_CONTROL_0, `DCSFR_IDX_DMA_CONTROL_1,
      `DCSFR_IDX_BIT_RATE_DIVIDER, `DCSFR_IDX_ADDRESS_MATCH_0,
      `DCSFR_IDX_CH0_SOURCE_LOW, `DCSFR_IDX_CH0_SOURCE_HIGH,
      `DCSFR_IDX_INTERFRAME_GAP, `DCSFR_IDX_ADDRESS_MATCH_1,
      `DCSFR_IDX_CH1_SOURCE_LOW, `DCSFR_IDX_CH1_SOURCE_HIGH,
      `DCSFR_IDX_SLOT_TIME, `DCSFR_IDX_ADDRESS_MATCH_2,
      `DCSFR_IDX_CH0_DEST_LOW, `DCSFR_IDX_CH0_DEST_HIGH,
      `DCSFR_IDX_BACKOFF_TIMER, `DCSFR_IDX_ADDRESS_MATCH_3,
      `DCSFR_IDX_EXTENSION_IRQ_ENABLE, `DCSFR_IDX_CH1_DEST_LOW,
      `DCSFR_IDX_CH1_DEST_HIGH, `DCSFR_IDX_COLLISION_COUNT,
      `DCSFR_IDX_ADDRESS_MASK_0, `DCSFR_IDX_TRANSMIT_STATE,
      `DCSFR_IDX_CH0_COUNT_LOW, `DCSFR_IDX_CH0_COUNT_HIGH,
      `DCSFR_IDX_PSEUDO_RANDOM_SEQ, `DCSFR_IDX_ADDRESS_MASK_1,
      `DCSFR_IDX_RECEIVE_STATE, `DCSFR_IDX_CH1_COUNT_LOW,
      `DCSFR_IDX_CH1_COUNT_HIGH, `DCSFR_IDX_RECEIVE_QUEUE,
      `DCSFR_IDX_OWN_SLOT_NUMBER, `DCSFR_IDX_EXTENSION_IRQ_PRIORITY: is_ext = 1'b1;
      default: is_ext = 1'b0;
    endcase
  endfunction

  // Status and receive queue slots are driven by the engine and the transmit queue reads zero; none is stored
  function automatic logic is_live(input logic [7:0] idx);
    unique case (idx)
      `DCSFR_IDX_RECEIVE_QUEUE, `DCSFR_IDX_TRANSMIT_STATE, `DCSFR_IDX_RECEIVE_STATE,
      `DCSFR_IDX_COLLISION_COUNT, `DCSFR_IDX_BACKOFF_TIMER, `DCSFR_IDX_TRANSMIT_QUEUE: is_live = 1'b1;
      default: is_live = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] pair(input dcsfr_byte_type lo, input dcsfr_byte_type hi);
    pair = {hi, lo};
  endfunction

  // Slot of a byte with a zero reset value; 4'hF marks every other index
  function automatic logic [3:0] zero_slot(input logic [7:0] idx);
    unique case (idx)
      `DCSFR_IDX_BIT_RATE_DIVIDER: zero_slot = 4'h0;
      `DCSFR_IDX_ADDRESS_MATCH_0: zero_slot = 4'h1;
      `DCSFR_IDX_ADDRESS_MATCH_1: zero_slot = 4'h2;
      `DCSFR_IDX_ADDRESS_MATCH_2: zero_slot = 4'h3;
      `DCSFR_IDX_ADDRESS_MATCH_3: zero_slot = 4'h4;
      `DCSFR_IDX_SLOT_TIME: zero_slot = 4'h5;
      `DCSFR_IDX_ADDRESS_MASK_0: zero_slot = 4'h6;
      `DCSFR_IDX_ADDRESS_MASK_1: zero_slot = 4'h7;
      `DCSFR_IDX_PSEUDO_RANDOM_SEQ: zero_slot = 4'h8;
      `DCSFR_IDX_OWN_SLOT_NUMBER: zero_slot = 4'h9;
      default: zero_slot = 4'hF;
    endcase
  endfunction

  // Word-aligned byte addresses only; low two bits must be zero
  assign index = apb_req.paddr[9:2];
  assign setup = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable;
  assign mapped = is_ext(index) && (apb_req.paddr[1:0] == 2'b00);
  assign writable = mapped && !is_live(index);
  assign wr_fire = access && apb_req.pwrite;
  assign rd_fire = access && !apb_req.pwrite;
  assign zslot = zero_slot(index);
  assign zeroed_hit = mapped && (zslot != 4'hF);

  // Zero-wait slave: the access phase always completes
  assign apb_rsp.pready = access;
  assign apb_rsp.pslverr = access && !mapped;
  assign apb_rsp.prdata = prdata_q;

  // Byte pairs have no reset value, so the store is written but never reset
  always_ff @(posedge pclk) begin
    if (wr_fire && writable) begin
      store[index] <= apb_req.pwdata[7:0];
    end
  end

  // Reset registers kept apart from the undefined store
  dcsfr_byte_type mode_q;
  dcsfr_byte_type ctl0_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `DCSFR_SERIAL_MODE_RESET;
      ctl0_q <= `DCSFR_RESET_ZERO;
    end else if (wr_fire && mapped) begin
      if (index == `DCSFR_IDX_SERIAL_CHANNEL_MODE) begin
        mode_q <= apb_req.pwdata[7:0];
      end
      if (index == `DCSFR_IDX_DMA_CONTROL_0) begin
        ctl0_q <= apb_req.pwdata[7:0];
      end
    end
  end

  // Zero-reset bytes; reset clears all slots, a write touches one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ZERO_SLOTS; i++) begin
        zeroed[i] <= `DCSFR_RESET_ZERO;
      end
    end else if (wr_fire && zeroed_hit) begin
      zeroed[zslot] <= apb_req.pwdata[7:0];
    end
  end

  always_comb begin
    next_rdata = `DCSFR_RESET_ZERO;
    if (mapped) begin
      unique case (index)
        `DCSFR_IDX_SERIAL_CHANNEL_MODE: next_rdata = mode_q;
        `DCSFR_IDX_DMA_CONTROL_0: next_rdata = ctl0_q;
        `DCSFR_IDX_RECEIVE_QUEUE: next_rdata = rx_queue_data;
        `DCSFR_IDX_TRANSMIT_STATE: next_rdata = transmit_state_in;
        `DCSFR_IDX_RECEIVE_STATE: next_rdata = receive_state_in;
        `DCSFR_IDX_COLLISION_COUNT: next_rdata = collision_count_in;
        `DCSFR_IDX_BACKOFF_TIMER: next_rdata = backoff_timer_in;
        // Write-only queue reads as zero
        `DCSFR_IDX_TRANSMIT_QUEUE: next_rdata = `DCSFR_RESET_ZERO;
        default: next_rdata = zeroed_hit ? zeroed[zslot] : store[index];
      endcase
    end
  end

  // Read data registered in the setup cycle, valid through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !apb_req.pwrite) begin
      prdata_q <= {24'h00_0000, next_rdata};
    end
  end

  // Queue strobes, one cycle after the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_push_q <= 1'b0;
      rx_pop_q <= 1'b0;
      tx_data_q <= `DCSFR_RESET_ZERO;
    end else begin
      tx_push_q <= wr_fire && mapped && (index == `DCSFR_IDX_TRANSMIT_QUEUE);
      rx_pop_q <= rd_fire && mapped && (index == `DCSFR_IDX_RECEIVE_QUEUE);
      if (wr_fire && mapped && (index == `DCSFR_IDX_TRANSMIT_QUEUE)) begin
        tx_data_q <= apb_req.pwdata[7:0];
      end
    end
  end

  assign tx_queue_push = tx_push_q;
  assign rx_queue_pop = rx_pop_q;
  assign tx_queue_data = tx_data_q;
  assign serial_channel_mode = mode_q;
  assign dma_control_0 = ctl0_q;
  assign dma_control_1 = store[`DCSFR_IDX_DMA_CONTROL_1];
  assign extension_irq_enable = store[`DCSFR_IDX_EXTENSION_IRQ_ENABLE];
  assign extension_irq_priority = store[`DCSFR_IDX_EXTENSION_IRQ_PRIORITY];

  // Channel values pair low and high bytes
  assign ch0.source = pair(store[`DCSFR_IDX_CH0_SOURCE_LOW], store[`DCSFR_IDX_CH0_SOURCE_HIGH]);
  assign ch0.dest = pair(store[`DCSFR_IDX_CH0_DEST_LOW], store[`DCSFR_IDX_CH0_DEST_HIGH]);
  assign ch0.count = pair(store[`DCSFR_IDX_CH0_COUNT_LOW], store[`DCSFR_IDX_CH0_COUNT_HIGH]);
  assign ch1.source = pair(store[`DCSFR_IDX_CH1_SOURCE_LOW], store[`DCSFR_IDX_CH1_SOURCE_HIGH]);
  assign ch1.dest = pair(store[`DCSFR_IDX_CH1_DEST_LOW], store[`DCSFR_IDX_CH1_DEST_HIGH]);
  assign ch1.count = pair(store[`DCSFR_IDX_CH1_COUNT_LOW], store[`DCSFR_IDX_CH1_COUNT_HIGH]);

  property p_unmapped_error;
    @(posedge pclk) disable iff (!presetn)
    access && !is_ext(index) |-> apb_rsp.pslverr;
  endproperty
  a_unmapped_error: assert property (p_unmapped_error) else $error("unmapped access not flagged");

  property p_ch0_src_low;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && mapped && index == `DCSFR_IDX_CH0_SOURCE_LOW |=> ch0.source[7:0] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_ch0_src_low: assert property (p_ch0_src_low) else $error("ch0 source low not stored");

  property p_ch1_src_high;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && mapped && index == `DCSFR_IDX_CH1_SOURCE_HIGH |=> ch1.source[15:8] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_ch1_src_high: assert property (p_ch1_src_high) else $error("ch1 source high not stored");

  property p_ch0_dest_high;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && mapped && index == `DCSFR_IDX_CH0_DEST_HIGH |=> ch0.dest[15:8] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_ch0_dest_high: assert property (p_ch0_dest_high) else $error("ch0 dest high not stored");

  property p_ch1_dest_low;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && mapped && index == `DCSFR_IDX_CH1_DEST_LOW |=> ch1.dest[7:0] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_ch1_dest_low: assert property (p_ch1_dest_low) else $error("ch1 dest low not stored");

  property p_ch0_count_low;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && mapped && index == `DCSFR_IDX_CH0_COUNT_LOW |=> ch0.count[7:0] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_ch0_count_low: assert property (p_ch0_count_low) else $error("ch0 count low not stored");

  property p_ch1_count_high;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && mapped && index == `DCSFR_IDX_CH1_COUNT_HIGH |=> ch1.count[15:8] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_ch1_count_high: assert property (p_ch1_count_high) else $error("ch1 count high not stored");

  property p_pair_readback;
    @(posedge pclk) disable iff (!presetn)
    setup && !apb_req.pwrite && apb_req.paddr == {`DCSFR_IDX_CH0_COUNT_HIGH, 2'b00}
      |=> apb_rsp.prdata[7:0] == ch0.count[15:8] && apb_rsp.prdata[31:8] == 24'h00_0000;
  endproperty
  a_pair_readback: assert property (p_pair_readback) else $error("count high readback mismatch");

  property p_push_once;
    @(posedge pclk) disable iff (!presetn)
    tx_queue_push |=> !tx_queue_push;
  endproperty
  a_push_once: assert property (p_push_once) else $error("queue push longer than one cycle");

  property p_ch0_src_high;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && mapped && index == `DCSFR_IDX_CH0_SOURCE_HIGH |=> ch0.source[15:8] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_ch0_src_high: assert property (p_ch0_src_high) else $error("ch0 source high not stored");

  property p_ch1_src_low;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && mapped && index == `DCSFR_IDX_CH1_SOURCE_LOW |=> ch1.source[7:0] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_ch1_src_low: assert property (p_ch1_src_low) else $error("ch1 source low not stored");

  property p_ch0_dest_low;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && mapped && index == `DCSFR_IDX_CH0_DEST_LOW |=> ch0.dest[7:0] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_ch0_dest_low: assert property (p_ch0_dest_low) else $error("ch0 dest low not stored");

  property p_ch1_dest_high;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && mapped && index == `DCSFR_IDX_CH1_DEST_HIGH |=> ch1.dest[15:8] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_ch1_dest_high: assert property (p_ch1_dest_high) else $error("ch1 dest high not stored");

  property p_ch0_count_high;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && mapped && index == `DCSFR_IDX_CH0_COUNT_HIGH |=> ch0.count[15:8] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_ch0_count_high: assert property (p_ch0_count_high) else $error("ch0 count high not stored");

  property p_ch1_count_low;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && mapped && index == `DCSFR_IDX_CH1_COUNT_LOW |=> ch1.count[7:0] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_ch1_count_low: assert property (p_ch1_count_low) else $error("ch1 count low not stored");

  property p_misaligned_error;
    @(posedge pclk) disable iff (!presetn)
    access && apb_req.paddr[1:0] != 2'b00 |-> apb_rsp.pslverr;
  endproperty
  a_misaligned_error: assert property (p_misaligned_error) else $error("misaligned access not flagged");

  property p_unmapped_read_zero;
    @(posedge pclk) disable iff (!presetn)
    setup && !apb_req.pwrite && !mapped
      |=> apb_rsp.prdata == 32'h0000_0000;
  endproperty
  a_unmapped_read_zero: assert property (p_unmapped_read_zero) else $error("unmapped read not zero");

  property p_zeroed_write;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && zeroed_hit |=> zeroed[$past(zslot)] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_zeroed_write: assert property (p_zeroed_write) else $error("zero-reset byte not stored");

  property p_pop_after_read;
    @(posedge pclk) disable iff (!presetn)
    rd_fire && mapped && index == `DCSFR_IDX_RECEIVE_QUEUE |=> rx_queue_pop;
  endproperty
  a_pop_after_read: assert property (p_pop_after_read) else $error("receive queue read without pop");

  property p_mode_write;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && mapped && index == `DCSFR_IDX_SERIAL_CHANNEL_MODE |=> serial_channel_mode == $past(apb_req.pwdata[7:0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("serial mode not stored");

  property p_ctl0_write;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && mapped && index == `DCSFR_IDX_DMA_CONTROL_0 |=> dma_control_0 == $past(apb_req.pwdata[7:0]);
  endproperty
  a_ctl0_write: assert property (p_ctl0_write) else $error("dma control 0 not stored");

  property p_tx_data;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && mapped && index == `DCSFR_IDX_TRANSMIT_QUEUE
      |=> tx_queue_push && tx_queue_data == $past(apb_req.pwdata[7:0]);
  endproperty
  a_tx_data: assert property (p_tx_data) else $error("transmit queue byte not pushed");

  property p_live_read;
    @(posedge pclk) disable iff (!presetn)
    setup && !apb_req.pwrite && mapped && index == `DCSFR_IDX_RECEIVE_STATE
      |=> apb_rsp.prdata[7:0] == $past(receive_state_in);
  endproperty
  a_live_read: assert property (p_live_read) else $error("receive state not read live");

  c_write_channel: cover property (@(posedge pclk) disable iff (!presetn)
    wr_fire && index == `DCSFR_IDX_CH1_COUNT_LOW);
  c_read_status: cover property (@(posedge pclk) disable iff (!presetn)
    rd_fire && index == `DCSFR_IDX_RECEIVE_STATE);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) apb_rsp.pslverr);
  c_queue_pop: cover property (@(posedge pclk) disable iff (!presetn) rx_queue_pop);
  c_zeroed_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_fire && zeroed_hit);
endmodule

// [rtl/dcsfr_pkg.sv]
package dcsfr_pkg;
  typedef logic [7:0] dcsfr_byte_type;

  typedef struct packed {
    logic [15:0] source;
    logic [15:0] dest;
    logic [15:0] count;
  } dcsfr_channel_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [9:0] paddr;
    logic [31:0] pwdata;
  } dcsfr_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dcsfr_apb_rsp_type;
endpackage

// [tb/dcsfr_engine_model.sv]
`timescale 1ns/10ps
// Receive side of the serial engine: a new byte after every pop
module dcsfr_engine_model #(
  parameter logic [7:0] FIRST_BYTE = 8'h5a,
  parameter logic [7:0] STEP = 8'h13
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Queue handshake
  input wire logic rx_queue_pop,
  output dcsfr_pkg::dcsfr_byte_type rx_queue_data
);
  import dcsfr_pkg::*;
  // Advances only on a pop, so an unread byte is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_queue_data <= FIRST_BYTE;
    end else if (rx_queue_pop) begin
      rx_queue_data <= rx_queue_data + STEP;
    end
  end
endmodule

// [tb/dcsfr_map_test.sv]
`timescale 1ns/10ps
`include "dcsfr_consts.svh"
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected %s expected %h seen %h", what, exp, got); end end

module dcsfr_map_test;
  import dcsfr_pkg::*;
  typedef struct packed {logic is_read; logic [31:0] data; logic err;} dcsfr_note_type;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  dcsfr_apb_req_type apb_req = '0;
  dcsfr_apb_rsp_type apb_rsp;
  dcsfr_channel_type ch0, ch1;
  dcsfr_byte_type mode, dc0, dc1, ien, ipri, tx_queue_data, rx_queue_data;
  dcsfr_byte_type st [4];
  logic tx_queue_push, rx_queue_pop;
  dcsfr_note_type notes[$];
  dcsfr_note_type note;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  bit held = 0;
  logic [7:0] vals [12];
  logic [7:0] cv [5];
  logic [7:0] dma_idx [12] = '{`DCSFR_IDX_CH0_SOURCE_LOW, `DCSFR_IDX_CH0_SOURCE_HIGH, `DCSFR_IDX_CH1_SOURCE_LOW,
    `DCSFR_IDX_CH1_SOURCE_HIGH, `DCSFR_IDX_CH0_DEST_LOW, `DCSFR_IDX_CH0_DEST_HIGH, `DCSFR_IDX_CH1_DEST_LOW,
    `DCSFR_IDX_CH1_DEST_HIGH, `DCSFR_IDX_CH0_COUNT_LOW, `DCSFR_IDX_CH0_COUNT_HIGH, `DCSFR_IDX_CH1_COUNT_LOW,
    `DCSFR_IDX_CH1_COUNT_HIGH};
  logic [7:0] ctl_idx [5] = '{`DCSFR_IDX_SERIAL_CHANNEL_MODE, `DCSFR_IDX_DMA_CONTROL_0, `DCSFR_IDX_DMA_CONTROL_1,
    `DCSFR_IDX_EXTENSION_IRQ_ENABLE, `DCSFR_IDX_EXTENSION_IRQ_PRIORITY};
  logic [7:0] st_idx [4] = '{`DCSFR_IDX_TRANSMIT_STATE, `DCSFR_IDX_RECEIVE_STATE, `DCSFR_IDX_COLLISION_COUNT,
    `DCSFR_IDX_BACKOFF_TIMER};
  logic [7:0] zero_idx [10] = '{`DCSFR_IDX_BIT_RATE_DIVIDER, `DCSFR_IDX_ADDRESS_MATCH_0,
    `DCSFR_IDX_ADDRESS_MATCH_1, `DCSFR_IDX_ADDRESS_MATCH_2, `DCSFR_IDX_ADDRESS_MATCH_3, `DCSFR_IDX_SLOT_TIME,
    `DCSFR_IDX_ADDRESS_MASK_0, `DCSFR_IDX_ADDRESS_MASK_1, `DCSFR_IDX_PSEUDO_RANDOM_SEQ,
    `DCSFR_IDX_OWN_SLOT_NUMBER};

  always #20 pclk = ~pclk;

  dcsfr_map dcsfr_map_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .ch0(ch0),
    .ch1(ch1), .serial_channel_mode(mode), .dma_control_0(dc0), .dma_control_1(dc1), .extension_irq_enable(ien),
    .extension_irq_priority(ipri), .tx_queue_push(tx_queue_push), .tx_queue_data(tx_queue_data),
    .rx_queue_pop(rx_queue_pop), .rx_queue_data(rx_queue_data), .transmit_state_in(st[0]),
    .receive_state_in(st[1]), .collision_count_in(st[2]), .backoff_timer_in(st[3]));

  dcsfr_engine_model dcsfr_engine_model_inst (.pclk(pclk), .presetn(presetn), .rx_queue_pop(rx_queue_pop),
    .rx_queue_data(rx_queue_data));

  task automatic results();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hold keeps psel up so the next setup follows the access at once
  task automatic apb(input logic wr, input logic [9:0] addr, input logic [7:0] data, input logic [7:0] exp,
                     input logic err, input bit hold);
    if (!held) @(posedge pclk);
    notes.push_back('{!wr, {24'h00_0000, exp}, err});
    apb_req.psel <= 1'b1;
    apb_req.pwrite <= wr;
    apb_req.paddr <= addr;
    apb_req.pwdata <= {24'h00_0000, data};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    // No fixed wait: only the bench watchdog ends a stalled transfer
    do @(posedge pclk);
    while (apb_rsp.pready !== 1'b1);
    apb_req.penable <= 1'b0;
    if (!hold) apb_req.psel <= 1'b0;
    held = hold;
  endtask

  // Results taken at the completing edge, while the request still stands
  always @(posedge pclk) begin
    if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      `CHK("pslverr", note.err, apb_rsp.pslverr)
      if (note.is_read) `CHK("prdata", note.data, apb_rsp.prdata)
    end
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    void'($urandom(32'hf21a));
    repeat (6) @(posedge pclk);
    for (int i = 0; i < 4; i++) st[i] <= 8'($urandom);
    presetn <= 1'b1;
    `CHK("reset controls", 16'h0000, {mode, dc0})
    apb(0, {`DCSFR_IDX_SERIAL_CHANNEL_MODE, 2'b00}, 8'h00, 8'h00, 1'b0, 1);
    apb(0, {`DCSFR_IDX_DMA_CONTROL_0, 2'b00}, 8'h00, 8'h00, 1'b0, 0);
    for (int i = 0; i < 12; i++) begin
      vals[i] = 8'($urandom);
      apb(1, {dma_idx[i], 2'b00}, vals[i], 8'h00, 1'b0, 1);
    end
    for (int i = 0; i < 12; i++) apb(0, {dma_idx[i], 2'b00}, 8'h00, vals[i], 1'b0, i != 11);
    @(negedge pclk);
    `CHK("ch0", {vals[1], vals[0], vals[5], vals[4], vals[9], vals[8]}, ch0)
    `CHK("ch1", {vals[3], vals[2], vals[7], vals[6], vals[11], vals[10]}, ch1)
    apb(1, {8'hE0, 2'b00}, 8'h55, 8'h00, 1'b1, 1);
    apb(0, {8'h80, 2'b00}, 8'h00, 8'h00, 1'b1, 1);
    apb(1, {`DCSFR_IDX_CH0_SOURCE_LOW, 2'b01}, ~vals[0], 8'h00, 1'b1, 0);
    for (int i = 0; i < 5; i++) begin
      cv[i] = 8'($urandom);
      apb(1, {ctl_idx[i], 2'b00}, cv[i], 8'h00, 1'b0, i != 4);
    end
    @(negedge pclk);
    `CHK("ch0 kept", {vals[1], vals[0]}, ch0.source)
    `CHK("controls", {cv[0], cv[1], cv[2], cv[3], cv[4]}, {mode, dc0, dc1, ien, ipri})
    for (int i = 0; i < 10; i++) begin
      apb(1, {zero_idx[i], 2'b00}, ~vals[i], 8'h00, 1'b0, 1);
      apb(0, {zero_idx[i], 2'b00}, 8'h00, ~vals[i], 1'b0, 1);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1, {st_idx[i], 2'b00}, ~st[i], 8'h00, 1'b0, 1);
      apb(0, {st_idx[i], 2'b00}, 8'h00, st[i], 1'b0, i != 3);
    end
    apb(1, {`DCSFR_IDX_TRANSMIT_QUEUE, 2'b00}, vals[3], 8'h00, 1'b0, 0);
    @(negedge pclk);
    `CHK("tx push", {1'b1, vals[3]}, {tx_queue_push, tx_queue_data})
    @(negedge pclk);
    `CHK("tx push end", 1'b0, tx_queue_push)
    apb(0, {`DCSFR_IDX_TRANSMIT_QUEUE, 2'b00}, 8'h00, 8'h00, 1'b0, 0);
    apb(0, {`DCSFR_IDX_RECEIVE_QUEUE, 2'b00}, 8'h00, 8'h5a, 1'b0, 0);
    @(negedge pclk);
    `CHK("rx pop", 1'b1, rx_queue_pop)
    apb(0, {`DCSFR_IDX_RECEIVE_QUEUE, 2'b00}, 8'h00, 8'h6d, 1'b0, 0);
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    `CHK("mid reset", 16'h0000, {mode, dc0})
    @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) apb(0, {zero_idx[i], 2'b00}, 8'h00, `DCSFR_RESET_ZERO, 1'b0, 1);
    apb(0, {`DCSFR_IDX_CH1_COUNT_HIGH, 2'b00}, 8'h00, vals[11], 1'b0, 0);
    repeat (2) @(posedge pclk);
    results();
  end
endmodule
